/* verification/ddrsm_checker.sv */
// port assertions for the ddr special-mode controller
module ddrsm_checker #(
  parameter int ROWS = 4,
  parameter int HA_W = 32
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic mode_wr_i,
  input wire logic [2:0] mode_data_i,
  input wire logic host_we_i,
  input wire logic [HA_W-1:0] host_addr_line_i,
  input wire logic host_ack_o,
  input wire logic suspend_i,
  input wire logic lp_exit_i,
  input wire logic [ROWS-1:0] cke_o,
  input wire logic cs_n_o,
  input wire logic ras_n_o,
  input wire logic cas_n_o,
  input wire logic we_n_o,
  input wire logic [1:0] ba_o,
  input wire logic [12:0] mem_addr_line_o,
  input wire logic [2:0] special_mode_select_o,
  input wire logic self_refresh_o
);
  // command nibble: chip select, ras, cas, we
  logic [3:0] cmd;
  logic [2:0] sm;
  assign cmd = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
  assign sm = special_mode_select_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  reset_clear_a: assert property ($rose(reset_n_i) |-> sm == 3'h0 && cke_o == '0)
    else $error("mode or cke not clear after reset");
  cke_rise_a: assert property ($rose(|cke_o) |->
    $past(mode_wr_i && mode_data_i != 3'h0) || $past(self_refresh_o))
    else $error("cke rose without cause");
  mode_store_a: assert property (mode_wr_i |=> sm == $past(mode_data_i))
    else $error("mode field not stored");
  nop_cmd_a: assert property (host_ack_o && sm == 3'h1 |-> cmd == 4'h7)
    else $error("nop mode gave another command");
  prea_cmd_a: assert property (host_ack_o && sm == 3'h2 |-> cmd == 4'h2 && mem_addr_line_o[10])
    else $error("precharge all wrong");
  mrs_map_a: assert property (host_ack_o && sm == 3'h3 |-> cmd == 4'h0 && ba_o == 2'h0 &&
    mem_addr_line_o == {1'b0, host_addr_line_i[13], 1'b0, host_addr_line_i[12:3]})
    else $error("mode register load wrong");
  cbr_cmd_a: assert property (host_ack_o && sm == 3'h6 |-> cmd == 4'h1 && &cke_o)
    else $error("refresh mode gave another command");
  normal_rw_a: assert property (host_ack_o && sm == 3'h0 |->
    cmd == {3'h2, !host_we_i} && |cke_o)
    else $error("ordinary access wrong");
  // refresh and the state change leave the same edge, so the refresh stands
  // in the first self-refresh cycle and the precharge-all in the one before
  sr_entry_a: assert property ($rose(self_refresh_o) |->
    cmd == 4'h1 && $past(cmd) == 4'h2 && (!suspend_i || cke_o == '0))
    else $error("self refresh entry wrong");
  // an ordinary access opens its row one cycle ahead of the column command
  act_row_a: assert property (host_ack_o && sm == 3'h0 |-> $past(cmd) == 4'h3 &&
    $past(mem_addr_line_o) == host_addr_line_i[25:13])
    else $error("row open missing before access");
  sr_exit_a: assert property (self_refresh_o && lp_exit_i && !suspend_i |=>
    !self_refresh_o && &cke_o)
    else $error("self refresh exit wrong");
endmodule // ddrsm_checker

bind ddrsm_ctrl ddrsm_checker #(.ROWS(ROWS), .HA_W(HA_W)) ddrsm_checker_i (.*);

/* verification/ddrsm_ctrl_tb.sv */
// self-checking bench for the ddr special-mode controller
module ddrsm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, reset_n_i, mode_wr_i, host_req_i, host_we_i, host_ack_o, suspend_i;
  logic lp_enter_i, lp_is_c3_i, lp_exit_i, cs_n_o, ras_n_o, cas_n_o, we_n_o, self_refresh_o;
  logic [2:0] mode_data_i, special_mode_select_o;
  logic [3:0] c3_row_powerdown_select_i, cke_o, sel;
  logic [1:0] ba_o;
  logic [12:0] mem_addr_line_o, mrs_val;
  logic [18:0] cmdv; // command, bank and address as seen
  logic [31:0] host_addr_line_i, seed, a;
  logic [37:0] e; // mask over expected value
  logic [37:0] exp_q[$];
  logic [2:0] modes[9] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h6, 3'h4, 3'h0, 3'h0};
  logic [2:0] cas[3] = '{3'h1, 3'h2, 3'h6};
  int n_fail, checks_done, cyc;
  assign cmdv = {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, mem_addr_line_o};
  // short exit wait keeps the power scenarios brief
  ddrsm_ctrl #(.XSR_CYC(2)) ddrsm_ctrl_i (.*);
  ddrsm_mem_model ddrsm_mem_model_i (.mclk_i, .cmd_i(cmdv[18:15]), .ma_i(mem_addr_line_o),
    .mrs_val_o(mrs_val));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // mask and expected value of the answered cycle for a mode
  function automatic logic [37:0] want(input logic [2:0] m);
    case (m)
      3'h2: return {19'h78400, 4'h2, 15'h0400};
      3'h3: return {19'h7FFFF, 7'h00, a[13], 1'b0, a[12:3]};
      3'h6: return {19'h78000, 4'h1, 15'h0000};
      3'h0: return {19'h7FFFF, 3'h2, !host_we_i, a[27:26], 3'h1, a[12:3]};
      default: return {19'h78000, 4'h7, 15'h0000};
    endcase
  endfunction
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic set_mode(input logic [2:0] m);
    mode_wr_i = 1'b1;
    mode_data_i = m;
    tick(1);
    // a waiting request is taken one edge later, so no spare cycle here
    mode_wr_i = 1'b0;
  endtask
  // request held until the answer, dropped in the cycle it is seen
  task automatic host();
    int i;
    host_addr_line_i = a;
    host_req_i = 1'b1;
    do begin
      tick(1);
      i++;
    end while (host_ack_o !== 1'b1 && i < 50);
    host_req_i = 1'b0;
    tick(1);
  endtask
  task automatic wait_sr(input logic lvl);
    int i;
    while (self_refresh_o !== lvl && i < 50) begin
      tick(1);
      i++;
    end
    chk(19'(self_refresh_o), 19'(lvl));
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // takes the oldest note whenever a host cycle is answered
  always @(posedge mclk_i) begin
    #1;
    cyc++;
    if (host_ack_o === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      chk(cmdv & e[37:19], e[18:0]);
    end
    if (cyc > 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    seed = 32'hAF141E6B;
    {reset_n_i, mode_wr_i, host_req_i, host_we_i, suspend_i, lp_enter_i} = '0;
    {lp_is_c3_i, lp_exit_i, mode_data_i, c3_row_powerdown_select_i} = '0;
    host_addr_line_i = 32'h0;
    tick(8);
    reset_n_i = 1'b1;
    // a request waiting while the clock enables are still off
    a = rnd();
    exp_q.push_back(want(3'h1));
    host_addr_line_i = a;
    host_req_i = 1'b1;
    tick(6);
    chk(19'({special_mode_select_o, cke_o}), 19'h0);
    set_mode(3'h1);
    host();
    foreach (modes[k]) begin
      a = (rnd() & 32'hFFFFC87F) | {22'h0, cas[k % 3], 7'h00};
      host_we_i = seed[31];
      set_mode(modes[k]);
      chk(19'({special_mode_select_o, cke_o}), 19'({modes[k], 4'hF}));
      exp_q.push_back(want(modes[k]));
      host();
      if (modes[k] == 3'h3) chk(19'(mrs_val), 19'(want(3'h3)));
    end
    // low power: subset of rows, then all rows, each followed by an access
    for (int c = 1; c >= 0; c--) begin
      sel = 4'(rnd()) | 4'h1;
      lp_is_c3_i = c[0];
      c3_row_powerdown_select_i = sel;
      lp_enter_i = 1'b1;
      wait_sr(1'b1);
      lp_enter_i = 1'b0;
      chk(19'(cke_o), {15'h0, (c ? ~sel : 4'h0)});
      tick(3);
      lp_exit_i = 1'b1;
      tick(1);
      lp_exit_i = 1'b0;
      chk(19'({self_refresh_o, cke_o}), 19'h0000F);
      tick(4);
      a = rnd();
      exp_q.push_back(want(3'h0));
      host();
    end
    // suspend ignores a low-power exit; only a reset leaves it
    suspend_i = 1'b1;
    wait_sr(1'b1);
    lp_exit_i = 1'b1;
    tick(3);
    chk(19'({self_refresh_o, cke_o}), 19'h00010);
    {lp_exit_i, suspend_i, reset_n_i} = 3'h0;
    tick(2);
    reset_n_i = 1'b1;
    tick(2);
    chk(19'({special_mode_select_o, cke_o}), 19'h0);
    set_mode(3'h6);
    chk(19'(cke_o), 19'h0000F);
    chk(19'(exp_q.size()), 19'h0);
    close_out();
  end
endmodule // ddrsm_ctrl_tb

/* verification/ddrsm_mem_model.sv */
// behavioural ddr memory: keeps the last mode register load
module ddrsm_mem_model (
  input wire logic mclk_i,
  input wire logic [3:0] cmd_i,
  input wire logic [12:0] ma_i,
  output logic [12:0] mrs_val_o
);
  // all four strobes low load the mode register; other commands leave it alone
  always @(posedge mclk_i) begin
    if (cmd_i == 4'h0) begin
      mrs_val_o <= ma_i;
    end
  end
endmodule // ddrsm_mem_model

/* verilog/ddrsm_cmd_enc.sv */
// ddr command encoder: command code to chip-select, ras, cas, we levels
module ddrsm_cmd_enc (
  input wire ddrsm_pkg::ddrsm_cmd_type cmd_i,
  output logic [3:0] ctl_n_o
);

  // {cs_n, ras_n, cas_n, we_n}, all active low on the pins
  always_comb begin
    unique case (cmd_i)
      ddrsm_pkg::CMD_NOP: ctl_n_o = 4'h7;
      ddrsm_pkg::CMD_PRE: ctl_n_o = 4'h2;
      ddrsm_pkg::CMD_MRS: ctl_n_o = 4'h0;
      ddrsm_pkg::CMD_REF: ctl_n_o = 4'h1;
      ddrsm_pkg::CMD_ACT: ctl_n_o = 4'h3;
      ddrsm_pkg::CMD_RD: ctl_n_o = 4'h5;
      ddrsm_pkg::CMD_WR: ctl_n_o = 4'h4;
      default: ctl_n_o = 4'h7; // unused code falls back to nop
    endcase
  end

endmodule // ddrsm_cmd_enc

/* verilog/ddrsm_ctrl.sv */
// ddr special-mode controller: init commands, clock enables, self-refresh
module ddrsm_ctrl #(
  parameter int ROWS = 4,
  parameter int HA_W = 32,
  parameter int XSR_CYC = ddrsm_pkg::XSR_CYC_DEF
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // special mode select write strobe and value
  input wire logic mode_wr_i,
  input wire logic [2:0] mode_data_i,
  // host memory cycle, request held until ack
  input wire logic host_req_i,
  input wire logic host_we_i,
  input wire logic [HA_W-1:0] host_addr_line_i,
  output logic host_ack_o,
  // power management indications
  input wire logic suspend_i,
  input wire logic lp_enter_i,
  input wire logic lp_is_c3_i,
  input wire logic [ROWS-1:0] c3_row_powerdown_select_i,
  input wire logic lp_exit_i,
  // ddr interface
  output logic [ROWS-1:0] cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [1:0] ba_o,
  output logic [12:0] mem_addr_line_o,
  // status
  output logic [2:0] special_mode_select_o,
  output logic self_refresh_o
);

  // refuse row counts, address widths and exit waits the logic cannot serve
  if (ROWS < 1 || ROWS > 8) begin : g_rows_chk
    $error("ddrsm_ctrl: ROWS must be 1 to 8");
  end
  if (HA_W < ddrsm_pkg::BANK_LSB + 2) begin : g_ha_chk
    $error("ddrsm_ctrl: HA_W too small for bank field");
  end
  if (XSR_CYC < 1 || XSR_CYC > 255) begin : g_xsr_chk
    $error("ddrsm_ctrl: XSR_CYC must be 1 to 255");
  end

  // all state of the block
  typedef struct packed {
    ddrsm_pkg::ddrsm_state_type st; // sequencer state
    logic [2:0] mode; // special mode select field
    logic cke_en; // clock enables released by a nonzero mode write
    logic [ROWS-1:0] sr_rows; // rows held in self-refresh
    logic suspended; // suspend entry, left only by reset
    ddrsm_pkg::ddrsm_cmd_type cmd; // command driven this cycle
    logic [1:0] ba; // bank lines
    logic [12:0] ma; // memory address lines
    logic ack; // host cycle done pulse
    logic [7:0] cnt; // self-refresh exit wait
  } ddrsm_regs_type;

  ddrsm_regs_type r; // registered state
  ddrsm_regs_type next_r; // next state
  logic [3:0] ctl_n; // encoded command pins
  logic pwr_req; // a power request is waiting

  assign pwr_req = suspend_i | lp_enter_i;

  // next-state logic
  always_comb begin
    next_r = r;
    next_r.cmd = ddrsm_pkg::CMD_NOP;
    next_r.ack = 1'b0;
    // mode field write; zero is stored with no other effect
    if (mode_wr_i) begin
      next_r.mode = mode_data_i;
      if (mode_data_i != ddrsm_pkg::MODE_RESET) begin
        next_r.cke_en = 1'b1;
      end
    end
    unique case (r.st)
      ddrsm_pkg::ST_IDLE: begin
        // power requests win over new host cycles, which wait
        if (pwr_req && r.cke_en) begin
          next_r.st = ddrsm_pkg::ST_SR_PRE;
        end else if (host_req_i && r.cke_en && !r.ack) begin
          next_r.ma = 13'h0000;
          next_r.ba = 2'h0;
          unique case (r.mode)
            ddrsm_pkg::MODE_NOP: begin
              next_r.cmd = ddrsm_pkg::CMD_NOP;
              next_r.ack = 1'b1;
            end
            ddrsm_pkg::MODE_PREALL: begin
              next_r.cmd = ddrsm_pkg::CMD_PRE;
              next_r.ma[ddrsm_pkg::AP_BIT] = 1'b1;
              next_r.ack = 1'b1;
            end
            ddrsm_pkg::MODE_MRS: begin
              // host 13:3 onto memory 11 and 9:0; software owns 7 and 12:9 content
              next_r.cmd = ddrsm_pkg::CMD_MRS;
              next_r.ma[9:0] = host_addr_line_i[12:3];
              next_r.ma[11] = host_addr_line_i[13];
              next_r.ack = 1'b1;
            end
            ddrsm_pkg::MODE_CBR: begin
              next_r.cmd = ddrsm_pkg::CMD_REF;
              next_r.ack = 1'b1;
            end
            ddrsm_pkg::MODE_NORMAL: begin
              // ordinary access opens the row first
              next_r.cmd = ddrsm_pkg::CMD_ACT;
              next_r.ma = host_addr_line_i[ddrsm_pkg::ROW_LSB +: 13];
              next_r.ba = host_addr_line_i[ddrsm_pkg::BANK_LSB +: 2];
              next_r.st = ddrsm_pkg::ST_ACT;
            end
            default: begin
              // reserved codes complete the cycle with a nop
              next_r.cmd = ddrsm_pkg::CMD_NOP;
              next_r.ack = 1'b1;
            end
          endcase
        end
      end
      ddrsm_pkg::ST_ACT: begin
        // column access with auto precharge; an in-flight cycle is
        // finished here before any power request is honoured
        next_r.cmd = host_we_i ? ddrsm_pkg::CMD_WR : ddrsm_pkg::CMD_RD;
        next_r.ma = 13'h0000;
        next_r.ma[9:0] = host_addr_line_i[ddrsm_pkg::COL_LSB +: 10];
        next_r.ma[ddrsm_pkg::AP_BIT] = 1'b1;
        next_r.ack = 1'b1;
        next_r.st = ddrsm_pkg::ST_IDLE;
      end
      ddrsm_pkg::ST_SR_PRE: begin
        // close every bank so self-refresh may be entered
        next_r.cmd = ddrsm_pkg::CMD_PRE;
        next_r.ma = 13'h0000;
        next_r.ma[ddrsm_pkg::AP_BIT] = 1'b1;
        next_r.st = ddrsm_pkg::ST_SR_ENTER;
      end
      ddrsm_pkg::ST_SR_ENTER: begin
        // refresh with clock enable dropping on the chosen rows
        next_r.cmd = ddrsm_pkg::CMD_REF;
        next_r.ma = 13'h0000;
        if (suspend_i || !lp_is_c3_i) begin
          next_r.sr_rows = {ROWS{1'b1}};
        end else begin
          next_r.sr_rows = c3_row_powerdown_select_i;
        end
        next_r.suspended = suspend_i;
        next_r.st = ddrsm_pkg::ST_SELFREF;
      end
      ddrsm_pkg::ST_SELFREF: begin
        // suspend is left only through reset; low power exits on its own
        if (lp_exit_i && !r.suspended) begin
          next_r.sr_rows = {ROWS{1'b0}};
          next_r.cnt = 8'(XSR_CYC);
          next_r.st = ddrsm_pkg::ST_SR_EXIT;
        end
      end
      ddrsm_pkg::ST_SR_EXIT: begin
        // nops while the devices recover, then normal operation
        if (r.cnt <= 8'h01) begin
          next_r.cnt = 8'h00;
          next_r.st = ddrsm_pkg::ST_IDLE;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      default: begin
        next_r.st = ddrsm_pkg::ST_IDLE; // unused code recovers
      end
    endcase
  end

  // registers; reset clears the mode field and holds clock enables off
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      r.st <= ddrsm_pkg::ST_IDLE;
      r.mode <= ddrsm_pkg::MODE_RESET;
      r.cke_en <= 1'b0;
      r.sr_rows <= '0;
      r.suspended <= 1'b0;
      r.cmd <= ddrsm_pkg::CMD_NOP;
      r.ba <= 2'h0;
      r.ma <= 13'h0000;
      r.ack <= 1'b0;
      r.cnt <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  // command pin encoding
  ddrsm_cmd_enc u_enc (
    .cmd_i(r.cmd),
    .ctl_n_o(ctl_n)
  );

  // outputs, all from the registered state
  assign cke_o = {ROWS{r.cke_en}} & ~r.sr_rows;
  assign cs_n_o = ctl_n[3];
  assign ras_n_o = ctl_n[2];
  assign cas_n_o = ctl_n[1];
  assign we_n_o = ctl_n[0];
  assign ba_o = r.ba;
  assign mem_addr_line_o = r.ma;
  assign host_ack_o = r.ack;
  assign special_mode_select_o = r.mode;
  assign self_refresh_o = (r.st == ddrsm_pkg::ST_SELFREF);

endmodule // ddrsm_ctrl

/* verilog/ddrsm_pkg.sv */
// constants, command codes and states for the ddr special-mode controller
//
// Function
// - clock enables low until nonzero mode written
// - suspend flushes commands, all rows self-refresh
// - resume reset clears mode, clock enables off
// - low-power flushes, rows or subset self-refresh
// - low-power exit leaves self-refresh without software
// - mode 001 turns memory cycles into nop
// - mode 010 turns memory cycles into precharge-all
// - mode 011 issues mode-register set, address mapped
// - reset clears mode; writing zero is harmless
// - mode 110 turns memory cycles into refresh
package ddrsm_pkg;

  // special mode select codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_NOP = 3'h1;
  localparam logic [2:0] MODE_PREALL = 3'h2;
  localparam logic [2:0] MODE_MRS = 3'h3;
  localparam logic [2:0] MODE_CBR = 3'h6;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // host address fields for ordinary accesses
  localparam int COL_LSB = 3;
  localparam int ROW_LSB = 13;
  localparam int BANK_LSB = 26;
  // memory address bit that carries auto precharge
  localparam int AP_BIT = 10;
  // self-refresh exit wait in memory clocks
  localparam int XSR_CYC_DEF = 20;

  // ddr commands presented to the encoder
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_PRE = 3'b001,
    CMD_MRS = 3'b010,
    CMD_REF = 3'b011,
    CMD_ACT = 3'b100,
    CMD_RD = 3'b101,
    CMD_WR = 3'b110
  } ddrsm_cmd_type;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACT = 3'b001,
    ST_SR_PRE = 3'b010,
    ST_SR_ENTER = 3'b011,
    ST_SELFREF = 3'b100,
    ST_SR_EXIT = 3'b101
  } ddrsm_state_type;

endpackage : ddrsm_pkg
